// ==== shared/rlth_pkg.sv ====
// constants for the second receiver loss-of-signal range/threshold bank
// assumes a byte-wide register port driven by the serial slave outside
//
// Contract
// - range register, high code 6:4, low 2:0
// - range register sets quick-trip full scale
// - each range code maps to fixed full scale
// - both range codes default to 000b
// - reads need level2, or level1 plus table2 permit
// - range writes need level2, or level1 plus readwrite
// - threshold writes also need quick-trip enable low
// - high threshold sets high loss reference
// - low threshold sets low loss reference
// - thresholds form a hysteresis comparator
// - strength below low threshold sets low alarm
// - low alarm holds until above high threshold
// - above high clears low, sets high alarm
// - range and thresholds survive power cycles
// - same storage seen through both slave addresses
package rlth_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RLTH_OFS_RANGE = 8'hB8;
  localparam logic [7:0] RLTH_OFS_RSVD  = 8'hB9;
  localparam logic [7:0] RLTH_OFS_HIGH  = 8'hBA;
  localparam logic [7:0] RLTH_OFS_LOW   = 8'hBB;

  // ----------------------------------------------------------------
  // range register fields
  // ----------------------------------------------------------------
  localparam int         RLTH_HI_LSB     = 4;
  localparam int         RLTH_LO_LSB     = 0;
  localparam logic [7:0] RLTH_RANGE_MASK = 8'h77;

  // factory default of the stored image (range, high, low)
  localparam logic [23:0] RLTH_NV_DEFAULT = 24'h000000;

  // full scale per range code, in microvolts
  localparam logic [20:0] RLTH_FS_UV [8] = '{
    21'h1312D0, 21'h0F436C, 21'h0CB840, 21'h098BC0,
    21'h07A378, 21'h065DB0, 21'h0575A8, 21'h04C6A8};

  // hysteresis states
  typedef enum logic [1:0] {
    RLTH_ST_CLEAR = 2'b00,
    RLTH_ST_LOW   = 2'b01,
    RLTH_ST_HIGH  = 2'b10
  } rlth_state_t;

endpackage : rlth_pkg

// ==== shared/rlth_mon_if.sv ====
// bundle between the register bank and the hysteresis monitor
// assumes both ends share one clock
`timescale 1ns/10ps
interface rlth_mon_if;
  logic [7:0] high_level;
  logic [7:0] low_level;
  logic [7:0] strength;
  logic       los_low;
  logic       los_high;

  modport bank (output high_level, output low_level, output strength,
                input los_low, input los_high);
  modport mon  (input high_level, input low_level, input strength,
                output los_low, output los_high);
endinterface : rlth_mon_if

// ==== rtl/rlth_hyst.sv ====
// hysteresis loss-of-signal monitor for the second receiver
// assumes strength is already synchronised to clk
`timescale 1ns/10ps
module rlth_hyst (
  input wire logic clk,
  input wire logic rstn,
  rlth_mon_if.mon  m
);

  rlth_pkg::rlth_state_t state;
  rlth_pkg::rlth_state_t next_state;
  logic                  below;
  logic                  above;

  // ----------------------------------------------------------------
  // comparisons
  // ----------------------------------------------------------------
  // strict compares: a level equal to a threshold changes nothing
  assign below = m.strength < m.low_level;
  assign above = m.strength > m.high_level;

  // from clear either crossing sets a state; otherwise only the crossing opposite to the current state
  always_comb begin
    next_state = state;
    unique case (state)
      rlth_pkg::RLTH_ST_CLEAR: begin
        if (above) next_state = rlth_pkg::RLTH_ST_HIGH;
        else if (below) next_state = rlth_pkg::RLTH_ST_LOW;
      end
      rlth_pkg::RLTH_ST_LOW: begin
        if (above) next_state = rlth_pkg::RLTH_ST_HIGH;
      end
      rlth_pkg::RLTH_ST_HIGH: begin
        if (below) next_state = rlth_pkg::RLTH_ST_LOW;
      end
      default: next_state = rlth_pkg::RLTH_ST_CLEAR;
    endcase
  end

  // state and alarm flags, registered together
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state      <= rlth_pkg::RLTH_ST_CLEAR;
      m.los_low  <= 1'b0;
      m.los_high <= 1'b0;
    end else begin
      state      <= next_state;
      m.los_low  <= next_state == rlth_pkg::RLTH_ST_LOW;
      m.los_high <= next_state == rlth_pkg::RLTH_ST_HIGH;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_low_set: assert property (below && !above |=> m.los_low)
    else $error("low alarm not set below low threshold");
  chk_low_hold: assert property (m.los_low && !above |=> m.los_low)
    else $error("low alarm dropped without high crossing");
  // with inverted thresholds the high state leaves on the low crossing
  chk_high_swap: assert property (
    above && !(m.los_high && below) |=> m.los_high && !m.los_low)
    else $error("high crossing did not swap alarms");
  chk_alarm_excl: assert property (!(m.los_low && m.los_high))
    else $error("both alarms set");

  cov_low_then_high: cover property (m.los_low ##[1:20] m.los_high);
  cov_high_then_low: cover property (m.los_high ##[1:20] m.los_low);

endmodule : rlth_hyst

// ==== rtl/rlth_bank.sv ====
// register bank and alarm top for the second receiver loss-of-signal
// range select and high/low trip levels.
// assumes the serial slave outside presents single-cycle byte
// requests with the slave address hits already decoded, and that the
// password engine and quick-trip enable run on the same clock.
`timescale 1ns/10ps
module rlth_bank (
  input  wire logic        clk,
  input  wire logic        rstn,
  // byte register port from the serial slave
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [1:0]  reg_sel,
  output logic      [7:0]  reg_rdata,
  output logic             reg_read_ok,
  // access state from the password engine
  input  wire logic        level1_password_access,
  input  wire logic        level2_password_access,
  input  wire logic        table2_readwrite_permit,
  input  wire logic        table2_readonly_permit,
  input  wire logic        second_quicktrip_enable,
  // converted signal strength, asynchronous to clk
  input  wire logic [7:0]  rx2_signal_strength,
  // nonvolatile image: restored at reset, stored after writes
  input  wire logic [23:0] nv_image,
  output logic             nv_store,
  output logic      [23:0] nv_data,
  // steering of the analog comparator
  output logic      [7:0]  rx2_los_range_select,
  output logic      [7:0]  rx2_high_trip_level,
  output logic      [7:0]  rx2_low_trip_level,
  output logic      [20:0] high_fs_uv,
  output logic      [20:0] low_fs_uv,
  // alarms
  output logic             rx2_signal_loss_low,
  output logic             rx2_signal_loss_high
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] strength_meta;
  logic [7:0] strength_sync;
  logic       bank_hit;
  logic       rd_ok;
  logic       wr_cfg_ok;
  logic       wr_trip_ok;
  logic       wr_range;
  logic       wr_high;
  logic       wr_low;
  logic [7:0] next_rdata;
  logic       mon_los_low;
  logic       mon_los_high;

  rlth_mon_if mon_bus ();

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  // two stages; the code is assumed to change slowly against clk, so
  // a word torn across bits lasts one cycle; the hysteresis does not filter it,
  // so one cycle past a threshold sets an alarm, and no handshake is used
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strength_meta <= 8'h00;
      strength_sync <= 8'h00;
    end else begin
      strength_meta <= rx2_signal_strength;
      strength_sync <= strength_meta;
    end
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // either slave address reaches the same storage
  assign bank_hit = |reg_sel;

  // read grant
  assign rd_ok = level2_password_access |
                 (level1_password_access &
                  (table2_readwrite_permit | table2_readonly_permit));
  // above

  // write grant for the range register
  assign wr_cfg_ok = level2_password_access |
                     (level1_password_access & table2_readwrite_permit);
  // above

  // trip levels are locked while the quick-trip runs, whatever level
  assign wr_trip_ok = wr_cfg_ok & ~second_quicktrip_enable;

  // accepted writes per register; others drop silently
  assign wr_range = reg_wr & bank_hit & wr_cfg_ok &
                    (reg_addr == rlth_pkg::RLTH_OFS_RANGE);
  assign wr_high  = reg_wr & bank_hit & wr_trip_ok &
                    (reg_addr == rlth_pkg::RLTH_OFS_HIGH);
  assign wr_low   = reg_wr & bank_hit & wr_trip_ok &
                    (reg_addr == rlth_pkg::RLTH_OFS_LOW);

  // ----------------------------------------------------------------
  // range register
  // ----------------------------------------------------------------
  // reset restores the stored image, so contents survive power loss
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx2_los_range_select <= nv_image[23:16] &
                              rlth_pkg::RLTH_RANGE_MASK;
    end else if (wr_range) begin
      // reserved bits 7 and 3 are never stored
      rx2_los_range_select <= reg_wdata &
                              rlth_pkg::RLTH_RANGE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // trip level registers
  // ----------------------------------------------------------------
  // high trip level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx2_high_trip_level <= nv_image[15:8];
    end else if (wr_high) begin
      rx2_high_trip_level <= reg_wdata;
    end
  end

  // low trip level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx2_low_trip_level <= nv_image[7:0];
    end else if (wr_low) begin
      rx2_low_trip_level <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile store request
  // ----------------------------------------------------------------
  // one pulse after each accepted write; the image is the live
  // registers, already updated on the same edge as the pulse
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nv_store <= 1'b0;
    end else begin
      nv_store <= wr_range | wr_high | wr_low;
    end
  end

  assign nv_data = {rx2_los_range_select, rx2_high_trip_level,
                    rx2_low_trip_level};

  // ----------------------------------------------------------------
  // full-scale selection
  // ----------------------------------------------------------------
  // registered so the comparator reference never glitches on a write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      high_fs_uv <= rlth_pkg::RLTH_FS_UV[0];
      low_fs_uv  <= rlth_pkg::RLTH_FS_UV[0];
    end else begin
      high_fs_uv <= rlth_pkg::RLTH_FS_UV[
        rx2_los_range_select[rlth_pkg::RLTH_HI_LSB +: 3]];
      low_fs_uv  <= rlth_pkg::RLTH_FS_UV[
        rx2_los_range_select[rlth_pkg::RLTH_LO_LSB +: 3]];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // the reserved register and refused reads return zero
  always_comb begin
    next_rdata = 8'h00;
    if (bank_hit && rd_ok) begin
      unique case (reg_addr)
        rlth_pkg::RLTH_OFS_RANGE: next_rdata = rx2_los_range_select;
        rlth_pkg::RLTH_OFS_HIGH:  next_rdata = rx2_high_trip_level;
        rlth_pkg::RLTH_OFS_LOW:   next_rdata = rx2_low_trip_level;
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  // read answer one cycle after the request, held until the next one
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata   <= 8'h00;
      reg_read_ok <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata   <= next_rdata;
      reg_read_ok <= bank_hit & rd_ok;
    end
  end

  // ----------------------------------------------------------------
  // hysteresis monitor
  // ----------------------------------------------------------------
  assign mon_bus.high_level = rx2_high_trip_level;
  assign mon_bus.low_level  = rx2_low_trip_level;
  assign mon_bus.strength   = strength_sync;
  assign mon_los_low        = mon_bus.los_low;
  assign mon_los_high       = mon_bus.los_high;

  rlth_hyst u_hyst (
    .clk  (clk),
    .rstn (rstn),
    .m    (mon_bus.mon)
  );

  // alarm outputs, retimed so the ports come from local flops
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx2_signal_loss_low  <= 1'b0;
      rx2_signal_loss_high <= 1'b0;
    end else begin
      rx2_signal_loss_low  <= mon_los_low;
      rx2_signal_loss_high <= mon_los_high;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_range_denied: assert property (
    reg_wr && !wr_cfg_ok |=> $stable(rx2_los_range_select))
    else $error("range changed on refused write");

  chk_range_store: assert property (
    wr_range |=> rx2_los_range_select ==
                 ($past(reg_wdata) &
                  rlth_pkg::RLTH_RANGE_MASK))
    else $error("range write not stored with reserved bits clear");

  chk_trip_locked: assert property (
    reg_wr && second_quicktrip_enable |=>
      $stable(rx2_high_trip_level) &&
      $stable(rx2_low_trip_level))
    else $error("trip level changed while quick-trip enabled");

  chk_rsvd_zero: assert property (
    rx2_los_range_select[7] == 1'b0 &&
    rx2_los_range_select[3] == 1'b0)
    else $error("reserved range bits set");

  chk_read_refused: assert property (
    reg_rd && !rd_ok |=> reg_rdata == 8'h00 && !reg_read_ok)
    else $error("refused read returned data");

  chk_rsvd_read: assert property (
    reg_rd && reg_addr == rlth_pkg::RLTH_OFS_RSVD |=>
      reg_rdata == 8'h00)
    else $error("reserved register read nonzero");

  chk_fs_map: assert property (
    rx2_los_range_select[6:4] == 3'h0 ##1
    rx2_los_range_select[6:4] == 3'h0 |->
      high_fs_uv == rlth_pkg::RLTH_FS_UV[0])
    // above
    else $error("code 000b full scale wrong");

  chk_nv_pulse: assert property (
    wr_high |=> nv_store && nv_data[15:8] == $past(reg_wdata))
    else $error("store request or image missing after write");

  chk_alarm_retime: assert property (
    mon_los_low |=> rx2_signal_loss_low)
    else $error("low alarm not forwarded");

  cov_range_write: cover property (wr_range);
  cov_trip_locked: cover property (reg_wr && second_quicktrip_enable &&
                                   reg_addr == 8'hBA);
  cov_low_alarm: cover property (rx2_signal_loss_low);

endmodule : rlth_bank

// ==== test/rlth_host.sv ====
// host model: drives the byte register port and the access levels
// assumes the bench clock; requests change just after rising edges
`timescale 1ns/10ps
module rlth_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [1:0] reg_sel,
  output logic      [4:0] acc
);
  // idle port at time zero, no access held
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 2'h0;
    acc = 5'h00;
  end

  // access state {quick-trip, level2, level1, readwrite, readonly}
  task automatic lvl(input logic [4:0] v);
    @(posedge clk);
    acc <= v;
  endtask : lvl

  // one-cycle request; released address and data show the inverse, not the
  // last value, so a design that samples late sees garbage
  task automatic req(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic [1:0] s);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_sel <= s;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_sel <= 2'h0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : req
endmodule : rlth_host

// ==== test/rx2_los_threshold_hysteresis_tb_top.sv ====
// bench for the range/threshold bank and its loss-of-signal alarms
// assumes rlth_bank as top and rlth_host as the serial-side model
`timescale 1ns/10ps
module rx2_los_threshold_hysteresis_tb_top;
  logic        clk, rstn, reg_wr, reg_rd, reg_read_ok, rd_d;
  logic        nv_store, los_low, los_high;
  logic [1:0]  reg_sel;
  logic [4:0]  acc;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, strength;
  logic [7:0]  range_q, high_q, low_q, m_rng, m_hi;
  logic [20:0] high_fs, low_fs;
  logic [23:0] nv_image, nv_data;
  logic [8:0]  rd_q[$];
  int          err_total, n_checks, cyc;
  int          fs_tab[8] = '{1250000, 1000300, 833600, 625600,
                             500600, 417200, 357800, 313000};

  rlth_bank rlth_bank_inst (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_rdata(reg_rdata),
    .reg_read_ok(reg_read_ok), .level1_password_access(acc[2]),
    .level2_password_access(acc[3]), .table2_readwrite_permit(acc[1]),
    .table2_readonly_permit(acc[0]), .second_quicktrip_enable(acc[4]),
    .rx2_signal_strength(strength), .nv_image(nv_image),
    .nv_store(nv_store), .nv_data(nv_data),
    .rx2_los_range_select(range_q), .rx2_high_trip_level(high_q),
    .rx2_low_trip_level(low_q), .high_fs_uv(high_fs),
    .low_fs_uv(low_fs), .rx2_signal_loss_low(los_low),
    .rx2_signal_loss_high(los_high));
  rlth_host rlth_host_inst (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .acc(acc));

  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task automatic chk_out(input string nm, input logic [23:0] e,
                         input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_out

  task automatic chk_rd(input logic [8:0] g);
    logic [8:0] e;
    e = (rd_q.size() > 0) ? rd_q.pop_front() : 9'h1FF;
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] read answer expected %h seen %h", e, g);
    end
  endtask : chk_rd

  task automatic print_verdict();
    err_total += rd_q.size();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // random slave hit, either address reaches the same storage
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rlth_host_inst.req(1'b1, a, d, 2'($urandom_range(3, 1)));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    rd_q.push_back(e);
    rlth_host_inst.req(1'b0, a, 8'h00, 2'($urandom_range(3, 1)));
  endtask : rd

  // strength step, then wait past the 4-edge alarm latency
  task automatic step(input logic [7:0] s, input logic [1:0] e);
    @(posedge clk);
    strength <= s;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk_out("alarms", {22'h0, e}, {22'h0, los_low, los_high});
  endtask : step

  // clock, read-answer monitor and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) rd_d <= reg_rd && rstn;
  always @(negedge clk) begin
    if (rd_d) chk_rd({reg_read_ok, reg_rdata});
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic       rg, wg;
    clk = 1'b0;
    rstn = 1'b0;
    strength = 8'h00;
    nv_image = rlth_pkg::RLTH_NV_DEFAULT;
    rd_d = 1'b0;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(89));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rlth_host_inst.lvl(5'h08);
    rd(rlth_pkg::RLTH_OFS_RANGE, 9'h100);
    rd(rlth_pkg::RLTH_OFS_HIGH, 9'h100);
    rd(rlth_pkg::RLTH_OFS_LOW, 9'h100);
    chk_out("fs default", 24'd1250000, {3'h0, low_fs});
    $display("test reset defaults done");
    for (int c = 0; c < 8; c++) begin
      d = 8'h88 | 8'(c << 4) | 8'(7 - c);
      wr(rlth_pkg::RLTH_OFS_RANGE, d);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk_out("high fs", 24'(fs_tab[c]), {3'h0, high_fs});
      chk_out("low fs", 24'(fs_tab[7-c]), {3'h0, low_fs});
      rd(rlth_pkg::RLTH_OFS_RANGE, {1'b1, d & 8'h77});
    end
    $display("test range codes done");
    m_rng = 8'h70;
    m_hi = 8'h00;
    for (int i = 0; i < 32; i++) begin
      rlth_host_inst.lvl(5'(i));
      rg = i[3] | (i[2] & (i[1] | i[0]));
      wg = i[3] | (i[2] & i[1]);
      d = 8'($urandom);
      wr(rlth_pkg::RLTH_OFS_RANGE, d);
      if (wg) m_rng = d & 8'h77;
      d = 8'($urandom);
      wr(rlth_pkg::RLTH_OFS_HIGH, d);
      if (wg && !i[4]) m_hi = d;
      rd(rlth_pkg::RLTH_OFS_RANGE, rg ? {1'b1, m_rng} : 9'h000);
      rd(rlth_pkg::RLTH_OFS_HIGH, rg ? {1'b1, m_hi} : 9'h000);
      @(negedge clk);
      chk_out("range out", {16'h0, m_rng}, {16'h0, range_q});
      chk_out("high out", {16'h0, m_hi}, {16'h0, high_q});
    end
    $display("test access matrix done");
    rlth_host_inst.lvl(5'h18);
    wr(rlth_pkg::RLTH_OFS_LOW, 8'hAA);
    rd(rlth_pkg::RLTH_OFS_LOW,
       {1'b1, rlth_pkg::RLTH_NV_DEFAULT[7:0]});
    rlth_host_inst.lvl(5'h08);
    wr(rlth_pkg::RLTH_OFS_RSVD, 8'hFF);
    rd(rlth_pkg::RLTH_OFS_RSVD, 9'h100);
    wr(rlth_pkg::RLTH_OFS_HIGH, 8'h80);
    wr(rlth_pkg::RLTH_OFS_LOW, 8'h40);
    @(negedge clk);
    chk_out("store pulse", 24'h1, {23'h0, nv_store});
    chk_out("store data", {m_rng, 16'h8040}, nv_data);
    rd(rlth_pkg::RLTH_OFS_LOW, 9'h140);
    $display("test store and reserved done");
    step(8'h00, 2'b10);
    step(8'h60, 2'b10);
    step(8'h80, 2'b10);
    step(8'h90, 2'b01);
    step(8'h40, 2'b01);
    step(8'h20, 2'b10);
    $display("test hysteresis done");
    @(posedge clk);
    nv_image <= 24'hFF1234;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_out("restore", 24'h771234, {range_q, high_q, low_q});
    chk_out("fs restore", 24'(fs_tab[7]), {3'h0, high_fs});
    rd(rlth_pkg::RLTH_OFS_HIGH, 9'h112);
    repeat (2) @(posedge clk);
    $display("test restore done");
    print_verdict();
  end
endmodule : rx2_los_threshold_hysteresis_tb_top
